// *** rtl/light_load_defs.vh ***
`ifndef LIGHT_LOAD_DEFS_VH
`define LIGHT_LOAD_DEFS_VH

// Register byte offsets on the AHB-Lite slave.
`define REG_CTRL_OFS 8'h00
`define REG_STATUS_OFS 8'h04
`define REG_IRQ_STAT_OFS 8'h08
`define REG_IRQ_MASK_OFS 8'h0C
`define REG_WINDOW_OFS 8'h10

// Control register fields.
`define CTRL_ENABLE_BIT 0
`define CTRL_UNIPLANE_BIT 1
`define CTRL_RESET_VAL 32'h0000_0003

// Interrupt event bit positions.
`define IRQ_DCM_ENTRY_BIT 0
`define IRQ_CCM_RETURN_BIT 1
`define IRQ_OC_FAULT_BIT 2
`define IRQ_PSAVE_CHANGE_BIT 3
`define IRQ_WIDTH 4

// Consecutive positive-node cycles before the aux rail enters DCM.
`define AUX_DCM_CYCLES 4'h8

// Gate threshold rendered as a settle count: 1 V is reached within 20 ns.
`define GATE_FALL_NS 20
`define CLK_PERIOD_NS 4
`define GATE_FALL_CYCLES ((`GATE_FALL_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)

// Window base and its 33 percent step, in hundredths.
`define WINDOW_BASE_RESET 16'h0064
`define WINDOW_STEP_PCT 33

`endif

// *** rtl/phase_driver.v ***
`timescale 1ns/100ps
`default_nettype none
`include "light_load_defs.vh"

// One phase: break-before-make gate sequencing and diode emulation.
module phase_driver #(
  parameter [3:0] ENTRY_CYCLES = 4'h1
)
(
  input wire core_clk,
  input wire nrst,
  input wire cycle_start,
  input wire emulation_en,
  input wire phase_on,
  input wire shutdown,
  input wire node_positive,
  input wire high_gate_sense,
  input wire low_gate_sense,
  output reg high_side_drive,
  output reg low_side_drive,
  output wire gate_oe_n,
  output reg dcm_active,
  output reg dcm_enter,
  output reg ccm_return
);

  // Count of consecutive cycles that saw negative inductor current.
  reg [3:0] neg_count_reg;
  // Switch node seen positive during this cycle's low-side conduction.
  reg neg_seen_reg;
  // Switch node seen negative during this cycle's low-side conduction.
  reg pos_seen_reg;
  // Settle timer before a gate may turn on.
  reg [3:0] settle_reg;
  // Which gate the cycle wants: high at cycle start, then low.
  reg want_high_reg;

  // Outputs float whenever the phase is shut down.
  assign gate_oe_n = shutdown;

  // Gate sequencing with an enforced dead time on every transition.
  always @(posedge core_clk or negedge nrst)
  begin
    if (!nrst)
    begin
      high_side_drive <= 1'b0;
      low_side_drive <= 1'b0;
      want_high_reg <= 1'b0;
      settle_reg <= 4'h0;
    end
    else if (shutdown || !phase_on)
    begin
      // Shed or faulted phase holds both gates off.
      high_side_drive <= 1'b0;
      low_side_drive <= 1'b0;
      want_high_reg <= 1'b0;
      settle_reg <= 4'h0;
    end
    else
    begin
      if (cycle_start)
      begin
        want_high_reg <= 1'b1;
        low_side_drive <= 1'b0;
        settle_reg <= 4'h0;
      end
      else if (want_high_reg && high_side_drive)
      begin
        // High side pulse lasts one tick, then hand over to the low side.
        want_high_reg <= 1'b0;
        high_side_drive <= 1'b0;
        settle_reg <= 4'h0;
      end
      else if (want_high_reg)
      begin
        // Wait until the low gate has fallen below threshold.
        if (!low_gate_sense && settle_reg >= `GATE_FALL_CYCLES) // see RULE1
          high_side_drive <= 1'b1;
        else
          settle_reg <= settle_reg + 4'h1;
      end
      else if (!low_side_drive)
      begin
        // Low side turns on only after the high gate dropped, and not in a DCM stop.
        if (!high_gate_sense && settle_reg >= `GATE_FALL_CYCLES && !(dcm_active && neg_seen_reg)) // see RULE1
          low_side_drive <= 1'b1;
        else if (settle_reg < 4'hF)
          settle_reg <= settle_reg + 4'h1;
      end
      else if (dcm_active && node_positive)
      begin
        // Negative current in DCM: release the low side at once.
        low_side_drive <= 1'b0; // see RULE7
      end
    end
  end

  // Current-direction sampling while the low side conducts.
  always @(posedge core_clk or negedge nrst)
  begin
    if (!nrst)
    begin
      neg_seen_reg <= 1'b0;
      pos_seen_reg <= 1'b0;
    end
    else if (cycle_start)
    begin
      neg_seen_reg <= 1'b0;
      pos_seen_reg <= 1'b0;
    end
    else if (low_side_drive)
    begin
      // Positive node means negative current; negative node means positive current.
      if (node_positive) // see RULE4
        neg_seen_reg <= 1'b1;
      else
        pos_seen_reg <= 1'b1;
    end
    else if (dcm_active && !node_positive && !want_high_reg)
    begin
      // Body diode conducting positive current after the low side released.
      pos_seen_reg <= 1'b1;
    end
  end

  // Mode decision taken only at the cycle boundary.
  always @(posedge core_clk or negedge nrst)
  begin
    if (!nrst)
    begin
      dcm_active <= 1'b0;
      neg_count_reg <= 4'h0;
      dcm_enter <= 1'b0;
      ccm_return <= 1'b0;
    end
    else
    begin
      dcm_enter <= 1'b0;
      ccm_return <= 1'b0;
      if (!emulation_en || shutdown)
      begin
        // Forced continuous conduction.
        if (dcm_active && cycle_start)
        begin
          dcm_active <= 1'b0; // see RULE2
          ccm_return <= 1'b1;
        end
        neg_count_reg <= 4'h0;
      end
      else if (cycle_start) // see RULE14
      begin
        if (!dcm_active)
        begin
          if (neg_seen_reg)
          begin
            if (neg_count_reg + 4'h1 >= ENTRY_CYCLES) // see RULE5
            begin
              dcm_active <= 1'b1; // see RULE6
              dcm_enter <= 1'b1;
              neg_count_reg <= 4'h0;
            end
            else
              neg_count_reg <= neg_count_reg + 4'h1;
          end
          else
            neg_count_reg <= 4'h0;
        end
        else if (pos_seen_reg)
        begin
          // Positive current seen: continuous conduction from this cycle on.
          dcm_active <= 1'b0; // see RULE8
          ccm_return <= 1'b1;
        end
      end
    end
  end

endmodule

`default_nettype wire

// *** rtl/light_load_mode_control.v ***
// Function
// RULE1: Break-before-make: opposite gate below threshold first.
// RULE2: Power-save high forces continuous conduction everywhere.
// RULE3: Power-save low enables emulation in three regulators.
// RULE4: Sample node while low side conducts; invert.
// RULE5: Core regulators enter DCM on first detection.
// RULE6: Aux rail enters DCM after eight cycles.
// RULE7: In DCM, drop low side when node positive.
// RULE8: Negative node returns regulator to continuous next cycle.
// RULE9: DCM entry raises switching window by 33 percent.
// RULE10: Uniplane: two phases, shed one in power-save.
// RULE11: Processor asserts power-save only at light load.
// RULE12: Faults merge into one shared power-good output.
// RULE13: Overcurrent latches all gates high impedance until re-enable.
// RULE14: Synchronise inputs; change modes at cycle boundaries.
`timescale 1ns/100ps
`default_nettype none
`include "light_load_defs.vh"

module light_load_mode_control #(
  parameter PERIOD_CYCLES = 833
)
(
  input wire core_clk,
  input wire nrst,
  input wire [31:0] haddr,
  input wire [1:0] htrans,
  input wire hwrite,
  input wire [2:0] hsize,
  input wire [31:0] hwdata,
  input wire hsel,
  input wire hready,
  output reg [31:0] hrdata,
  output wire hreadyout,
  output wire hresp,
  input wire power_save_request_n,
  input wire [2:0] node_positive,
  input wire [2:0] high_gate_sense,
  input wire [2:0] low_gate_sense,
  input wire overcurrent,
  input wire overvoltage,
  input wire undervoltage,
  output wire [2:0] high_side_drive,
  output wire [2:0] low_side_drive,
  output wire [2:0] gate_oe_n,
  output wire supply_ok_flag_o,
  output wire supply_ok_flag_oe_n,
  output reg [15:0] core_window,
  output reg [15:0] aux_window,
  output wire irq
);

  // Channel 0 and 1 are core phases, channel 2 is the aux rail.
  // In uniplane use channels 0 and 1 form one regulator.
  localparam AUX = 2;

  // Window step: base plus 33 percent, saturating at the field width.
  // Both window outputs use it, so the step lives in one place.
  // The product fits in 24 bits; the clamp takes effect for bases above 49275.
  function [15:0] window_step;
    input [15:0] base;
    reg [23:0] prod;
    begin
      prod = {8'h00, base} * 24'd133 / 24'd100;
      window_step = (prod[23:16] != 8'h00) ? 16'hFFFF : prod[15:0];
    end
  endfunction

  // Two-stage synchronisers for power-save and node polarity.
  reg [3:0] sync1_reg;
  reg [3:0] sync2_reg;
  // Control register, window base, interrupt status and mask.
  reg [31:0] ctrl_reg;
  reg [15:0] window_base_reg;
  reg [`IRQ_WIDTH-1:0] irq_stat_reg;
  reg [`IRQ_WIDTH-1:0] irq_mask_reg;
  // Latched overcurrent shutdown.
  reg oc_latch_reg;
  // Power-save level applied at the cycle boundary.
  reg psave_reg;
  // Switching period counter.
  reg [15:0] period_reg;
  // AHB data-phase capture.
  reg wr_pend_reg;
  reg [7:0] wr_addr_reg;

  // Decoded control bits and the boundary strobe.
  // Shutdown covers a latched fault and a disabled block.
  wire enable = ctrl_reg[`CTRL_ENABLE_BIT];
  wire uniplane = ctrl_reg[`CTRL_UNIPLANE_BIT];
  wire cycle_start = (period_reg == 16'h0000);
  wire shutdown = oc_latch_reg || !enable;
  // Per-channel mode state and event pulses from the drivers.
  wire [2:0] dcm_active;
  wire [2:0] dcm_enter;
  wire [2:0] ccm_return;
  wire [2:0] phase_on;

  // Synchronise asynchronous-by-nature inputs before use.
  // Bit 3 is the power-save request, bits 2 to 0 the node polarity.
  // Reset loads ones: no power save, and a node level that is
  // ignored because no low side conducts right after reset.
  always @(posedge core_clk or negedge nrst)
  begin
    if (!nrst)
    begin
      sync1_reg <= 4'hF;
      sync2_reg <= 4'hF;
    end
    else
    begin
      sync1_reg <= {power_save_request_n, node_positive}; // see RULE14
      sync2_reg <= sync1_reg;
    end
  end

  // Free-running switching period; each wrap is a cycle boundary.
  // PERIOD_CYCLES sets the switching period in core clocks.
  // The count starts at zero, so the first edge is a boundary.
  // All mode decisions use this one strobe, keeping channels in step.
  always @(posedge core_clk or negedge nrst)
  begin
    if (!nrst)
      period_reg <= 16'h0000;
    else if (period_reg == PERIOD_CYCLES[15:0] - 16'h0001)
      period_reg <= 16'h0000;
    else
      period_reg <= period_reg + 16'h0001;
  end

  // Power-save level is taken only at cycle boundaries; low means save.
  // A change between boundaries waits, so no pulse is cut short.
  // Reset leaves the block in forced continuous conduction.
  always @(posedge core_clk or negedge nrst)
  begin
    if (!nrst)
      psave_reg <= 1'b0;
    else if (cycle_start) // see RULE14
      psave_reg <= !sync2_reg[3]; // see RULE11
  end

  // Overcurrent latches off until enable is toggled low.
  // The latch ignores overcurrent while disabled, so a fault still
  // present when enable goes low does not set it again.
  // Writing enable high then releases all three channels from shutdown.
  always @(posedge core_clk or negedge nrst)
  begin
    if (!nrst)
      oc_latch_reg <= 1'b0;
    else if (overcurrent && enable)
      oc_latch_reg <= 1'b1; // see RULE13
    else if (!enable)
      oc_latch_reg <= 1'b0;
  end

  // Shed the second core phase in uniplane power-save.
  // In dual-plane use both core channels keep running.
  // The aux rail never sheds.
  assign phase_on[0] = 1'b1;
  assign phase_on[1] = !(uniplane && psave_reg); // see RULE10
  assign phase_on[AUX] = 1'b1;

  // Core phases enter DCM at once; aux waits for eight cycles.
  // Every channel shares the boundary strobe and shutdown, and has
  // its own synchronised node polarity and gate sense inputs.
  // Only the entry count differs between core and aux.
  // The event pulses feed the interrupt status below.
  genvar gi;
  generate
    for (gi = 0; gi < 3; gi = gi + 1)
    begin : chan
      phase_driver #(
        .ENTRY_CYCLES((gi == AUX) ? `AUX_DCM_CYCLES : 4'h1) // see RULE6
      ) u_drv (
        .core_clk(core_clk),
        .nrst(nrst),
        .cycle_start(cycle_start),
        .emulation_en(psave_reg), // see RULE3
        .phase_on(phase_on[gi]),
        .shutdown(shutdown), // see RULE13
        .node_positive(sync2_reg[gi]),
        .high_gate_sense(high_gate_sense[gi]),
        .low_gate_sense(low_gate_sense[gi]),
        .high_side_drive(high_side_drive[gi]),
        .low_side_drive(low_side_drive[gi]),
        .gate_oe_n(gate_oe_n[gi]),
        .dcm_active(dcm_active[gi]),
        .dcm_enter(dcm_enter[gi]),
        .ccm_return(ccm_return[gi])
      );
    end
  endgenerate

  // Window outputs step up by a third while their regulator is in DCM.
  // The core window follows channel 0, which never sheds.
  // The outputs change one edge after the mode does.
  // Leaving DCM drops the window straight back to its base.
  always @(posedge core_clk or negedge nrst)
  begin
    if (!nrst)
    begin
      core_window <= `WINDOW_BASE_RESET;
      aux_window <= `WINDOW_BASE_RESET;
    end
    else
    begin
      core_window <= dcm_active[0] ? window_step(window_base_reg) : window_base_reg; // see RULE9
      aux_window <= dcm_active[AUX] ? window_step(window_base_reg) : window_base_reg; // see RULE9
    end
  end

  // Shared open-drain power-good: pulled low on any fault or shutdown.
  // The pin only drives low; a board pull-up gives the good level.
  // Overcurrent arrives through the latch, one edge later.
  // A disabled block also pulls it low.
  assign supply_ok_flag_o = 1'b0;
  assign supply_ok_flag_oe_n = !(shutdown || overvoltage || undervoltage); // see RULE12

  // Register map, one word each, decoded on the low address byte:
  // 0x00 control: bit 0 enable, bit 1 uniplane.
  // 0x04 status, read only: latch, power save, phases on, DCM.
  // 0x08 interrupt status, write one to clear.
  // 0x0C interrupt mask, same layout as the status.
  // 0x10 window base.
  // Unmapped offsets read zero and ignore writes.
  // Upper address bits are not decoded, so the map repeats.
  // AHB-Lite slave: zero wait states, always OKAY.
  assign hreadyout = 1'b1;
  assign hresp = 1'b0;
  wire take = hsel && hready && htrans[1];

  // Events for the interrupt status register.
  // Each event is a one-cycle pulse.
  // The overcurrent event fires on the edge that sets the latch.
  // The power-save event fires at the boundary where the applied
  // level is about to change.
  // A set beats a software clear in the same cycle.
  wire [`IRQ_WIDTH-1:0] events;
  assign events[`IRQ_DCM_ENTRY_BIT] = |dcm_enter;
  assign events[`IRQ_CCM_RETURN_BIT] = |ccm_return;
  assign events[`IRQ_OC_FAULT_BIT] = overcurrent && enable && !oc_latch_reg;
  assign events[`IRQ_PSAVE_CHANGE_BIT] = cycle_start && (psave_reg == sync2_reg[3]);

  // Address phase capture, register writes, and read data.
  // A write is held from its address phase and lands in the data
  // phase, when hwdata stands. A read is answered from the address
  // phase, so hrdata stands when the master samples it.
  always @(posedge core_clk or negedge nrst)
  begin
    if (!nrst)
    begin
      wr_pend_reg <= 1'b0;
      wr_addr_reg <= 8'h00;
      hrdata <= 32'h0000_0000;
      ctrl_reg <= `CTRL_RESET_VAL;
      window_base_reg <= `WINDOW_BASE_RESET;
      irq_stat_reg <= {`IRQ_WIDTH{1'b0}};
      irq_mask_reg <= {`IRQ_WIDTH{1'b0}};
    end
    else
    begin
      wr_pend_reg <= take && hwrite;
      wr_addr_reg <= haddr[7:0];
      // Write-one-to-clear, with new events winning over the clear.
      if (wr_pend_reg && wr_addr_reg == `REG_IRQ_STAT_OFS)
        irq_stat_reg <= (irq_stat_reg & ~hwdata[`IRQ_WIDTH-1:0]) | events;
      else
        irq_stat_reg <= irq_stat_reg | events;
      if (wr_pend_reg)
      begin
        case (wr_addr_reg)
          `REG_CTRL_OFS: ctrl_reg <= {30'h0000_0000, hwdata[1:0]};
          `REG_IRQ_MASK_OFS: irq_mask_reg <= hwdata[`IRQ_WIDTH-1:0];
          `REG_WINDOW_OFS: window_base_reg <= hwdata[15:0];
          default: ;
        endcase
      end
      // Read data registered at the address phase, so it stands in the data phase.
      if (take && !hwrite)
      begin
        case (haddr[7:0])
          `REG_CTRL_OFS: hrdata <= ctrl_reg;
          `REG_STATUS_OFS: hrdata <= {24'h00_0000, oc_latch_reg, psave_reg, phase_on,
                                      dcm_active};
          `REG_IRQ_STAT_OFS: hrdata <= {28'h000_0000, irq_stat_reg};
          `REG_IRQ_MASK_OFS: hrdata <= {28'h000_0000, irq_mask_reg};
          `REG_WINDOW_OFS: hrdata <= {16'h0000, window_base_reg};
          default: hrdata <= 32'h0000_0000;
        endcase
      end
    end
  end

  // Level interrupt while any unmasked status bit is set.
  // Status bits are sticky; only software clears them.
  // Masking hides a bit from the output but keeps it for polling.
  assign irq = |(irq_stat_reg & irq_mask_reg);

endmodule

`default_nettype wire

// *** verif/light_load_mode_control_chk.sv ***
`timescale 1ns/100ps
`default_nettype none
// Watches gate sequencing, mode windows and fault outputs at the top ports.
module light_load_mode_control_chk #(
  parameter PERIOD_CYCLES = 833
)
(
  input wire core_clk,
  input wire nrst,
  input wire power_save_request_n,
  input wire [2:0] low_gate_sense,
  input wire overcurrent,
  input wire overvoltage,
  input wire undervoltage,
  input wire [2:0] high_side_drive,
  input wire [2:0] low_side_drive,
  input wire [2:0] gate_oe_n,
  input wire supply_ok_flag_oe_n,
  input wire [15:0] core_window,
  input wire [15:0] aux_window,
  input wire irq
);
  // Age a power-save level must reach before its mode is judged settled.
  localparam int SETTLE = 2 * PERIOD_CYCLES + 8;
  reg [15:0] hi_cnt;
  reg [15:0] lo_cnt;
  // Each window raised by one step, for the step relation.
  wire [31:0] core_up = {16'h0000, core_window} * 32'h0000_0085 / 32'h0000_0064;
  wire [31:0] aux_up = {16'h0000, aux_window} * 32'h0000_0085 / 32'h0000_0064;
  default clocking @(posedge core_clk); endclocking
  default disable iff (!nrst);
  // Counts how long the request has held its level; a change restarts the count.
  always @(posedge core_clk or negedge nrst)
  begin
    if (!nrst)
    begin
      hi_cnt <= 16'h0000;
      lo_cnt <= 16'h0000;
    end
    else
    begin
      hi_cnt <= power_save_request_n ? hi_cnt + 16'h0001 : 16'h0000;
      lo_cnt <= power_save_request_n ? 16'h0000 : lo_cnt + 16'h0001;
    end
  end
  a_gate_no_overlap: assert property ((high_side_drive & low_side_drive) == 3'b000)
    else $error("both gates of a phase on");
  a_bbm_high_rise: assert property ((high_side_drive & ~$past(high_side_drive)
    & $past(low_gate_sense)) == 3'b000) else $error("high side rose over a charged low gate");
  a_ccm_forced: assert property (hi_cnt > SETTLE |-> core_window == aux_window)
    else $error("window raised while full power requested");
  a_phase_shed: assert property (lo_cnt > SETTLE |-> !high_side_drive[1])
    else $error("second phase switched in power save");
  a_window_step: assert property (core_window == aux_window
    || core_up == {16'h0000, aux_window} || aux_up == {16'h0000, core_window})
    else $error("window off the one step relation");
  a_oc_tristate: assert property (overcurrent |-> ##[1:4] gate_oe_n == 3'b111)
    else $error("drivers not released after overcurrent");
  a_oc_latched: assert property ($rose(&gate_oe_n) |=> (&gate_oe_n) [*4])
    else $error("drivers came back without re-enable");
  a_supply_ok_flag_fault: assert property ((overcurrent || overvoltage || undervoltage)
    |-> ##[1:6] !supply_ok_flag_oe_n) else $error("good flag not pulled low on fault");
  c_core_dcm: cover property (core_window > aux_window);
  c_oc_shut: cover property ($rose(&gate_oe_n));
  c_irq: cover property ($rose(irq));
endmodule
bind light_load_mode_control light_load_mode_control_chk #(.PERIOD_CYCLES(PERIOD_CYCLES)) u_chk (
  .core_clk, .nrst, .power_save_request_n, .low_gate_sense, .overcurrent, .overvoltage,
  .undervoltage, .high_side_drive, .low_side_drive, .gate_oe_n, .supply_ok_flag_oe_n,
  .core_window, .aux_window, .irq);
`default_nettype wire

// *** verif/switch_stage_model.sv ***
`timescale 1ns/100ps
`default_nettype none
// Power switches and switch node of three channels, as the controller sees them.
module switch_stage_model #(
  parameter DEPTH = 6
)
(
  input wire core_clk,
  input wire [2:0] high_side_drive,
  input wire [2:0] low_side_drive,
  input wire [2:0] reverse_current,
  output logic [2:0] high_gate_sense,
  output logic [2:0] low_gate_sense,
  output logic [2:0] node_positive
);
  // Recent gate commands; a released gate stays charged for DEPTH cycles.
  logic [3*DEPTH-1:0] high_hist = '0;
  logic [3*DEPTH-1:0] low_hist = '0;
  integer k;
  // Shifts the gate commands into the discharge history.
  always @(posedge core_clk)
  begin
    high_hist <= {high_hist[3*DEPTH-4:0], high_side_drive};
    low_hist <= {low_hist[3*DEPTH-4:0], low_side_drive};
  end
  // A gate reads above threshold while driven or still discharging.
  always @*
  begin
    high_gate_sense = high_side_drive;
    low_gate_sense = low_side_drive;
    for (k = 0; k < DEPTH; k = k + 1)
    begin
      high_gate_sense = high_gate_sense | high_hist[3*k +: 3];
      low_gate_sense = low_gate_sense | low_hist[3*k +: 3];
    end
  end
  // Node sits high under the upper switch; otherwise reversed current lifts it.
  assign node_positive = high_side_drive | reverse_current;
endmodule
`default_nettype wire

// *** verif/light_load_mode_control_tb_top.sv ***
`timescale 1ns/100ps
`default_nettype none
`include "light_load_defs.vh"
// Drives bus, power-save level and load direction; checks modes and faults.
module light_load_mode_control_tb_top;
  localparam int PERIOD = 40;
  localparam [31:0] BASE = 32'h0000_0064;
  logic core_clk = 1'b0;
  logic nrst = 1'b0;
  logic [31:0] haddr = 32'h0000_0000;
  logic [1:0] htrans = 2'b00;
  logic hwrite = 1'b0;
  logic [31:0] hwdata = 32'h0000_0000;
  logic hsel = 1'b0;
  logic power_save_request_n = 1'b1;
  logic [2:0] rev = 3'b000;
  logic overcurrent = 1'b0;
  logic undervoltage = 1'b0;
  logic overvoltage = 1'b0;
  wire [31:0] hrdata;
  wire hreadyout;
  wire [2:0] node_positive, high_gate_sense, low_gate_sense;
  wire [2:0] high_side_drive, low_side_drive, gate_oe_n;
  wire supply_ok_flag_oe_n, irq;
  wire [15:0] core_window, aux_window;
  int n_mismatch = 0;
  int check_count = 0;
  int seed = 32'hb22b_c3eb;
  int lo_ccm, lo_dcm;
  logic [31:0] rd, rnd, on_mask;
  light_load_mode_control #(.PERIOD_CYCLES(PERIOD)) DUT (.core_clk, .nrst, .haddr, .htrans,
    .hwrite, .hsize(3'b010), .hwdata, .hsel, .hready(hreadyout), .hrdata, .hreadyout,
    .hresp(), .power_save_request_n, .node_positive, .high_gate_sense, .low_gate_sense,
    .overcurrent, .overvoltage, .undervoltage, .high_side_drive, .low_side_drive,
    .gate_oe_n, .supply_ok_flag_o(), .supply_ok_flag_oe_n, .core_window, .aux_window, .irq);
  switch_stage_model u_stage (.core_clk, .high_side_drive, .low_side_drive,
    .reverse_current(rev), .high_gate_sense, .low_gate_sense, .node_positive);
  // Free-running core clock.
  initial forever #2 core_clk = ~core_clk;
  // One single word transfer; waits for the slave's ready in both phases.
  task bus(input logic w, input logic [31:0] a, input logic [31:0] wd);
  begin
    haddr <= a;
    htrans <= 2'b10;
    hwrite <= w;
    hsel <= 1'b1;
    @(posedge core_clk);
    while (hreadyout !== 1'b1) @(posedge core_clk);
    htrans <= 2'b00;
    hwdata <= wd;
    @(posedge core_clk);
    while (hreadyout !== 1'b1) @(posedge core_clk);
    rd = hrdata;
  end
  endtask
  // Counts a comparison and reports a difference at once.
  task chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
  begin
    check_count++;
    if (got !== exp)
    begin
      n_mismatch++;
      $display("mismatch %s expected %h seen %h", nm, exp, got);
    end
  end
  endtask
  // Expected window for a regulator in the given conduction mode.
  function logic [31:0] win(input logic dcm);
    win = dcm ? BASE * 32'h0000_0085 / 32'h0000_0064 : BASE;
  endfunction
  // Over two periods: high sides that switched, and phase 0 low side on-time.
  task watch(output int low_on);
  begin
    on_mask = 32'h0000_0000;
    low_on = 0;
    repeat (2 * PERIOD)
    begin
      @(posedge core_clk);
      on_mask = on_mask | high_side_drive;
      low_on = low_on + low_side_drive[0];
    end
  end
  endtask
  task per(input int n);
    repeat (n * PERIOD) @(posedge core_clk);
  endtask
  task end_sim;
  begin
    if (n_mismatch == 0 && check_count > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  end
  endtask
  // Main sequence: registers, random modes, directed modes, interrupt, faults.
  initial
  begin
    repeat (3) @(posedge core_clk);
    nrst <= 1'b1;
    bus(1'b0, `REG_CTRL_OFS, 32'h0000_0000);
    chk("ctrl", `CTRL_RESET_VAL, rd);
    bus(1'b0, `REG_WINDOW_OFS, 32'h0000_0000);
    chk("base", BASE, rd);
    bus(1'b1, 32'h0000_0020, 32'hFFFF_FFFF);
    bus(1'b0, 32'h0000_0020, 32'h0000_0000);
    chk("unmapped", 32'h0000_0000, rd);
    repeat (6)
    begin
      rnd = $random(seed);
      power_save_request_n <= rnd[0];
      rev <= rnd[3:1];
      per(2);
    end
    // Full power with reversed current: everything stays continuous.
    power_save_request_n <= 1'b1;
    rev <= 3'b101;
    per(4);
    chk("core ccm", win(1'b0), core_window);
    chk("aux ccm", win(1'b0), aux_window);
    watch(lo_ccm);
    chk("phases full", 32'h0000_0007, on_mask);
    // Power save: core enters at once, aux must wait eight cycles.
    power_save_request_n <= 1'b0;
    per(5);
    chk("core dcm", win(1'b1), core_window);
    chk("aux waits", win(1'b0), aux_window);
    watch(lo_dcm);
    chk("phase shed", 32'h0000_0005, on_mask);
    chk("low cut", 32'h0000_0001, lo_dcm < lo_ccm);
    per(6);
    chk("aux dcm", win(1'b1), aux_window);
    bus(1'b0, `REG_STATUS_OFS, 32'h0000_0000);
    chk("status", 32'h0000_006D, rd);
    rev <= 3'b000;
    per(3);
    chk("core back", win(1'b0), core_window);
    chk("aux back", win(1'b0), aux_window);
    // Power-save change event: raised, cleared, then masked.
    bus(1'b0, `REG_IRQ_STAT_OFS, 32'h0000_0000);
    chk("mode events", 32'h0000_0003, rd & 32'h0000_0003);
    bus(1'b1, `REG_IRQ_STAT_OFS, 32'h0000_000F);
    bus(1'b1, `REG_IRQ_MASK_OFS, 32'h0000_0008);
    @(posedge core_clk);
    chk("irq idle", 32'h0000_0000, irq);
    power_save_request_n <= 1'b1;
    per(2);
    chk("irq raised", 32'h0000_0001, irq);
    bus(1'b0, `REG_IRQ_STAT_OFS, 32'h0000_0000);
    chk("irq status", 32'h0000_0008, rd & 32'h0000_0008);
    bus(1'b1, `REG_IRQ_STAT_OFS, 32'h0000_0008);
    repeat (2) @(posedge core_clk);
    chk("irq cleared", 32'h0000_0000, irq);
    bus(1'b1, `REG_IRQ_MASK_OFS, 32'h0000_0000);
    power_save_request_n <= 1'b0;
    per(2);
    chk("irq masked", 32'h0000_0000, irq);
    bus(1'b0, `REG_IRQ_STAT_OFS, 32'h0000_0000);
    chk("masked stat", 32'h0000_0008, rd & 32'h0000_0008);
    // Overcurrent: drivers released and held off until re-enabled.
    overcurrent <= 1'b1;
    repeat (2) @(posedge core_clk);
    overcurrent <= 1'b0;
    repeat (4) @(posedge core_clk);
    chk("oc oe", 32'h0000_0007, gate_oe_n);
    chk("oc good", 32'h0000_0000, supply_ok_flag_oe_n);
    per(1);
    chk("oc held", 32'h0000_0007, gate_oe_n);
    bus(1'b0, `REG_IRQ_STAT_OFS, 32'h0000_0000);
    chk("oc event", 32'h0000_0004, rd & 32'h0000_0004);
    bus(1'b1, `REG_CTRL_OFS, 32'h0000_0000);
    bus(1'b1, `REG_CTRL_OFS, 32'h0000_0003);
    per(2);
    chk("restart", 32'h0000_0000, gate_oe_n);
    chk("good high", 32'h0000_0001, supply_ok_flag_oe_n);
    undervoltage <= 1'b1;
    repeat (6) @(posedge core_clk);
    chk("uv good", 32'h0000_0000, supply_ok_flag_oe_n);
    undervoltage <= 1'b0;
    overvoltage <= 1'b1;
    repeat (2) @(posedge core_clk);
    chk("ov good", 32'h0000_0000, supply_ok_flag_oe_n);
    end_sim;
  end
  // Cuts a hang short.
  initial
  begin
    repeat (20000) @(posedge core_clk);
    n_mismatch++;
    end_sim;
  end
endmodule
`default_nettype wire
